// ---- src/ppp_pkg.sv ----
// constants for the parallel absolute position port
package ppp_pkg;
  // word geometry
  localparam int OUT_W = 25;
  localparam int RES_MAX = 13;
  localparam int TURN_MAX = 16;
  localparam int RES_DEF = 13;
  localparam int TURN_DEF = 12;
  // timing
  localparam int CLK_HZ = 100_000_000;
  localparam int PRESET_MIN_MS = 100;
  localparam int PRESET_CYC = (PRESET_MIN_MS * (CLK_HZ / 1000));
  // register byte offsets
  localparam logic [3:0] OFS_POS = 4'h0;
  localparam logic [3:0] OFS_PRESET_VAL = 4'h4;
  localparam logic [3:0] OFS_CFG = 4'h8;
  // reset values
  localparam logic [OUT_W-1:0] PRESET_VAL_RST = 25'h0000000;
  // config register fields
  localparam int CFG_RES_LSB = 0;
  localparam int CFG_TURN_LSB = 8;
  localparam int CFG_GRAY_BIT = 16;
  // preset timer states, gray along the path
  typedef enum logic [1:0] {
    PST_IDLE = 2'b00,
    PST_HOLD = 2'b01,
    PST_DONE = 2'b11
  } ppp_pst_t;
endpackage

// ---- src/ppp_port.sv ----
// parallel absolute position port with avalon register access
// Notes on behaviour
// [RL1] data outputs are driven only while select is low.
// [RL2] with select high the data outputs are released.
// [RL3] freeze low tracks the live word, freeze high holds the last word.
// [RL4] code rises for clockwise steps with sense low and counter-clockwise steps with sense high.
// [RL5] preset held high at least 100 ms loads the preset value once.
// [RL6] the cover button triggers the same preset as the preset input.
// [RL7] the host ties every control input to a firm level, unused ones low.
// [RL8] the host leaves reserved lines unconnected.
// [RL9] resolution is a parameter of 0 to 13 bits.
// [RL10] turn count is a parameter of 0 to 16 bits.
// [RL11] the word is at most 25 bits and sits contiguously from bit zero.
// [RL12] a 10 by 7 build uses the lowest seventeen outputs only.
// [RL13] turns sit above the angle as one continuous count.
// [RL14] gray or binary code is chosen at build time for the whole word.
//
// Implementation choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
module ppp_port #(
  parameter int RES_BITS = ppp_pkg::RES_DEF,
  parameter int TURN_BITS = ppp_pkg::TURN_DEF,
  parameter bit GRAY = 1'b1,
  parameter int PRESET_CYCLES = ppp_pkg::PRESET_CYC
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // sensor steps
  input wire logic i_step,
  input wire logic i_step_cw,
  // control pins
  input wire logic i_sel_n,
  input wire logic i_freeze,
  input wire logic i_count_ccw,
  input wire logic i_preset_to_value,
  input wire logic i_button,
  // parallel data
  output logic [ppp_pkg::OUT_W-1:0] o_data,
  output logic [ppp_pkg::OUT_W-1:0] o_data_oe,
  // avalon slave
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest
);
  localparam int W = RES_BITS + TURN_BITS; // RL13
  localparam int CW = $clog2(PRESET_CYCLES + 1);
  localparam logic [CW-1:0] CYC_LAST = CW'(PRESET_CYCLES - 1);
  localparam logic [ppp_pkg::OUT_W-1:0] USED_MASK = ppp_pkg::OUT_W'((26'h1 << W) - 26'h1); // RL12

  generate
    if (RES_BITS < 0 || RES_BITS > ppp_pkg::RES_MAX || TURN_BITS < 0 || TURN_BITS > ppp_pkg::TURN_MAX
        || W < 1 || W > ppp_pkg::OUT_W || PRESET_CYCLES < 2) begin : g_bad_cfg // RL9 RL10 RL11
      $error("ppp_port: unsupported word configuration");
    end
  endgenerate

  function automatic logic [ppp_pkg::OUT_W-1:0] code_of(input logic [ppp_pkg::OUT_W-1:0] bin);
    code_of = GRAY ? (bin ^ (bin >> 1)) : bin; // RL14
  endfunction

  // position counter and preset timer
  logic [ppp_pkg::OUT_W-1:0] pos_reg, pos_next;
  logic [ppp_pkg::OUT_W-1:0] preset_val_reg, preset_val_next;
  ppp_pkg::ppp_pst_t pst_reg, pst_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic preset_req;
  logic preset_load;

  always_comb begin
    preset_req = i_preset_to_value | i_button; // RL6
    pst_next = pst_reg;
    cnt_next = cnt_reg;
    preset_load = 1'b0;
    pos_next = pos_reg;
    if (i_ce) begin
      case (pst_reg)
        ppp_pkg::PST_IDLE: begin
          if (preset_req) begin
            pst_next = ppp_pkg::PST_HOLD;
            cnt_next = CW'(1);
          end
        end
        ppp_pkg::PST_HOLD: begin
          if (!preset_req) begin
            pst_next = ppp_pkg::PST_IDLE;
          end else if (cnt_reg == CYC_LAST) begin
            pst_next = ppp_pkg::PST_DONE; // RL5
            preset_load = 1'b1;
          end else begin
            cnt_next = cnt_reg + CW'(1);
          end
        end
        ppp_pkg::PST_DONE: begin
          if (!preset_req) begin
            pst_next = ppp_pkg::PST_IDLE;
          end
        end
        default: begin
          pst_next = ppp_pkg::PST_IDLE;
        end
      endcase
      if (preset_load) begin
        pos_next = preset_val_reg & USED_MASK; // RL5
      end else if (i_step) begin
        if (i_step_cw ^ i_count_ccw) begin // RL4
          pos_next = (pos_reg + 25'h1) & USED_MASK; // RL13
        end else begin
          pos_next = (pos_reg - 25'h1) & USED_MASK;
        end
      end
    end
  end

  // output word and drive enables
  logic [ppp_pkg::OUT_W-1:0] out_reg, out_next;
  logic [ppp_pkg::OUT_W-1:0] oe_reg, oe_next;

  always_comb begin
    out_next = out_reg;
    oe_next = oe_reg;
    if (i_ce) begin
      if (!i_freeze) begin
        out_next = code_of(pos_reg) & USED_MASK; // RL3 RL11
      end
      oe_next = i_sel_n ? '0 : USED_MASK; // RL1 RL2
    end
  end

  assign o_data = out_reg;
  assign o_data_oe = oe_reg;

  // avalon register access
  logic ack_reg, ack_next;
  logic [31:0] rdata_reg, rdata_next;
  logic bus_req;
  logic bus_done;

  always_comb begin
    bus_req = i_avs_read | i_avs_write;
    bus_done = ack_reg & i_ce;
    ack_next = ack_reg;
    rdata_next = rdata_reg;
    preset_val_next = preset_val_reg;
    if (i_ce) begin
      ack_next = bus_req & ~ack_reg;
      if (bus_req && !ack_reg && i_avs_read) begin
        case ({i_avs_address[3:2], 2'b00})
          ppp_pkg::OFS_POS: rdata_next = 32'(pos_reg);
          ppp_pkg::OFS_PRESET_VAL: rdata_next = 32'(preset_val_reg);
          ppp_pkg::OFS_CFG: begin
            rdata_next = 32'h0;
            rdata_next[ppp_pkg::CFG_RES_LSB +: 5] = 5'(RES_BITS);
            rdata_next[ppp_pkg::CFG_TURN_LSB +: 5] = 5'(TURN_BITS);
            rdata_next[ppp_pkg::CFG_GRAY_BIT] = GRAY;
          end
          default: rdata_next = 32'h0;
        endcase
      end
      if (bus_done && i_avs_write && ({i_avs_address[3:2], 2'b00} == ppp_pkg::OFS_PRESET_VAL)) begin
        preset_val_next = i_avs_writedata[ppp_pkg::OUT_W-1:0] & USED_MASK;
      end
    end
  end

  assign o_avs_waitrequest = bus_req & ~bus_done;
  assign o_avs_readdata = rdata_reg;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pst_reg <= ppp_pkg::PST_IDLE;
      cnt_reg <= '0;
      pos_reg <= ppp_pkg::PRESET_VAL_RST;
      preset_val_reg <= ppp_pkg::PRESET_VAL_RST;
      out_reg <= '0;
      oe_reg <= '0;
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0;
    end else begin
      pst_reg <= pst_next;
      cnt_reg <= cnt_next;
      pos_reg <= pos_next;
      preset_val_reg <= preset_val_next;
      out_reg <= out_next;
      oe_reg <= oe_next;
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  // helper: consecutive cycles of preset request, saturating
  logic [CW-1:0] hi_cnt_reg, hi_cnt_next;
  always_comb begin
    hi_cnt_next = hi_cnt_reg;
    if (i_ce) begin
      if (!preset_req) begin
        hi_cnt_next = '0;
      end else if (hi_cnt_reg != CYC_LAST) begin
        hi_cnt_next = hi_cnt_reg + CW'(1);
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hi_cnt_reg <= '0;
    end else begin
      hi_cnt_reg <= hi_cnt_next;
    end
  end

  property p_drive_on;
    @(posedge i_clk_sys) disable iff (!i_rst_n) (i_ce && !i_sel_n) |=> (o_data_oe == USED_MASK);
  endproperty
  a_drive_on: assert property (p_drive_on) else $error("outputs not driven with select low"); // RL1

  property p_drive_off;
    @(posedge i_clk_sys) disable iff (!i_rst_n) (i_ce && i_sel_n) |=> (o_data_oe == '0);
  endproperty
  a_drive_off: assert property (p_drive_off) else $error("outputs driven with select high"); // RL2

  property p_hold;
    @(posedge i_clk_sys) disable iff (!i_rst_n) (i_freeze || !i_ce) |=> $stable(o_data);
  endproperty
  a_hold: assert property (p_hold) else $error("frozen word changed"); // RL3

  property p_track;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_ce && !i_freeze) ##1 (i_ce && !i_freeze) |=> (o_data == (code_of($past(pos_next, 2)) & USED_MASK));
  endproperty
  a_track: assert property (p_track) else $error("output word does not track position"); // RL3

  property p_count_sense;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_ce && i_step && !preset_load && (i_step_cw ^ i_count_ccw)) |=> (pos_reg == (($past(pos_reg) + 25'h1) & USED_MASK));
  endproperty
  a_count_sense: assert property (p_count_sense) else $error("count sense wrong"); // RL4

  property p_preset_time;
    @(posedge i_clk_sys) disable iff (!i_rst_n) preset_load |-> (hi_cnt_reg == CYC_LAST);
  endproperty
  a_preset_time: assert property (p_preset_time) else $error("preset loaded too early"); // RL5

  property p_preset_value;
    @(posedge i_clk_sys) disable iff (!i_rst_n) preset_load |=> (pos_reg == ($past(preset_val_reg) & USED_MASK));
  endproperty
  a_preset_value: assert property (p_preset_value) else $error("preset value not loaded"); // RL5

  property p_button;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_ce && i_button && hi_cnt_reg == CYC_LAST && pst_reg != ppp_pkg::PST_DONE) |-> preset_load;
  endproperty
  a_button: assert property (p_button) else $error("button did not preset"); // RL6

  property p_upper_zero;
    @(posedge i_clk_sys) disable iff (!i_rst_n) ((o_data & ~USED_MASK) == '0) && ((o_data_oe & ~USED_MASK) == '0);
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("unused outputs active"); // RL11 RL12

  property p_gray_step;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (GRAY && i_ce && !i_freeze && $past(i_ce) && !$past(i_freeze) && $changed(pos_reg) && !$past(preset_load))
      |=> ($countones(o_data ^ $past(o_data)) == 1);
  endproperty
  a_gray_step: assert property (p_gray_step) else $error("gray word moved more than one bit"); // RL14
endmodule // ppp_port
`default_nettype wire

// ---- tb/ppp_host.sv ----
// host controller model watching the parallel lines
`timescale 1ns/10ps
`default_nettype none
module ppp_host (
  // clock
  input wire logic i_clk_sys,
  // design side
  input wire logic [24:0] i_data,
  input wire logic [24:0] i_data_oe,
  // line levels seen by the host, data lines only, reserved lines left open
  output logic [24:0] o_line
);
  logic [24:0] last_reg = '0;
  // remember the last level each line was driven to
  always @(posedge i_clk_sys) begin
    for (int i = 0; i < 25; i++) begin
      if (i_data_oe[i]) begin
        last_reg[i] <= i_data[i];
      end
    end
  end
  // released push-pull lines float: show the inverse of the last driven level
  always_comb begin
    for (int i = 0; i < 25; i++) begin
      o_line[i] = i_data_oe[i] ? i_data[i] : ~last_reg[i];
    end
  end
endmodule // ppp_host
`default_nettype wire

// ---- tb/ppp_port_tb_top.sv ----
// self-checking bench for the position port
`timescale 1ns/10ps
`default_nettype none
module ppp_port_tb_top;
  localparam logic [24:0] MSK = 25'h001ffff;
  logic clk, rst_n, ce, step, cw, sel_n, frz, ccw, pre, btn, rd, wr, wq;
  logic [3:0] adr;
  logic [31:0] wd, rdat, rq;
  logic [24:0] dat, oe, line, pos;
  int err_count = 0, check_count = 0, cyc = 0;
  ppp_port #(.RES_BITS(7), .TURN_BITS(10), .GRAY(1'b1), .PRESET_CYCLES(4)) ppp_port_inst (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_ce(ce), .i_step(step), .i_step_cw(cw), .i_sel_n(sel_n),
    .i_freeze(frz), .i_count_ccw(ccw), .i_preset_to_value(pre), .i_button(btn), .o_data(dat),
    .o_data_oe(oe), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wq));
  ppp_host ppp_host_inst (.i_clk_sys(clk), .i_data(dat), .i_data_oe(oe), .o_line(line));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      print_verdict;
    end
  end
  function automatic logic [31:0] gw(input logic [24:0] p);
    return {7'h00, p ^ (p >> 1)};
  endfunction
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
    end while (wq !== 1'b0);
    rq = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic mv(input logic c, input int k);
    for (int i = 0; i < k; i++) begin
      @(posedge clk);
      step <= 1'b1;
      cw <= c;
      @(posedge clk);
      step <= 1'b0;
      pos = ((c ^ ccw) ? pos + 25'h1 : pos - 25'h1) & MSK;
    end
    repeat (3) @(posedge clk);
  endtask
  task automatic s_regs;
    bus(1'b0, 4'h4, 32'h0);
    chk(rq, 32'(ppp_pkg::PRESET_VAL_RST));
    bus(1'b0, 4'h8, 32'h0);
    chk(rq, 32'h00010a07);
    bus(1'b1, 4'h4, 32'hffff0005);
    bus(1'b0, 4'h4, 32'h0);
    chk(rq, 32'h00010005);
    bus(1'b1, 4'h0, 32'h00000abc);
    bus(1'b0, 4'h0, 32'h0);
    chk(rq, 32'h0);
    bus(1'b0, 4'hc, 32'h0);
    chk(rq, 32'h0);
  endtask
  task automatic s_move;
    mv(1'b1, 3);
    chk({7'h00, dat}, gw(pos));
    chk({7'h00, oe}, {7'h00, MSK});
    chk({7'h00, line & MSK}, gw(pos));
    ccw <= 1'b1;
    mv(1'b1, 5);
    chk({7'h00, dat}, gw(pos));
    bus(1'b0, 4'h0, 32'h0);
    chk(rq, 32'h0001fffe);
    ccw <= 1'b0;
  endtask
  task automatic s_freeze;
    logic [24:0] held;
    held = dat;
    frz <= 1'b1;
    mv(1'b1, 2);
    chk({7'h00, dat}, {7'h00, held});
    frz <= 1'b0;
    repeat (3) @(posedge clk);
    chk({7'h00, dat}, gw(pos));
  endtask
  task automatic s_sel;
    sel_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk({7'h00, oe}, 32'h0);
    chk({7'h00, line & MSK}, ~gw(pos) & {7'h00, MSK});
    sel_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk({7'h00, oe}, {7'h00, MSK});
  endtask
  task automatic s_ce;
    logic [24:0] held;
    held = dat;
    ce <= 1'b0;
    @(posedge clk);
    step <= 1'b1;
    cw <= 1'b1;
    @(posedge clk);
    step <= 1'b0;
    repeat (3) @(posedge clk);
    chk({7'h00, dat}, {7'h00, held});
    ce <= 1'b1;
    repeat (3) @(posedge clk);
    chk({7'h00, dat}, gw(pos));
  endtask
  task automatic s_preset(input logic b);
    mv(1'b1, 1);
    @(posedge clk);
    pre <= ~b;
    btn <= b;
    repeat (3) @(posedge clk);
    pre <= 1'b0;
    btn <= 1'b0;
    bus(1'b0, 4'h0, 32'h0);
    chk(rq, {7'h00, pos});
    @(posedge clk);
    pre <= ~b;
    btn <= b;
    repeat (4) @(posedge clk);
    pre <= 1'b0;
    btn <= 1'b0;
    pos = 25'h0010005;
    bus(1'b0, 4'h0, 32'h0);
    chk(rq, {7'h00, pos});
    repeat (2) @(posedge clk);
    chk({7'h00, dat}, gw(pos));
  endtask
  initial begin
    {rst_n, step, cw, sel_n, frz, ccw, pre, btn, rd, wr} = '0;
    ce = 1'b1;
    adr = 4'h0;
    wd = 32'h0;
    pos = 25'h0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk({7'h00, dat}, 32'h0);
    s_regs();
    s_move();
    s_freeze();
    s_sel();
    s_ce();
    s_preset(1'b0);
    s_preset(1'b1);
    print_verdict();
  end
endmodule // ppp_port_tb_top
`default_nettype wire
